// File: logic/operating_mode_controller.v
`timescale 1ns/1ps
`include "mode_ctl_defs.vh"
// ---------------------------------------------------------------
// Operating-mode sequencer
// ---------------------------------------------------------------
module operating_mode_controller (
   // Clock and reset
   input  wire       mclk,
   input  wire       rst,
   // Pins and analogue comparators
   input  wire       flash_level,
   input  wire       chip_select_n,
   input  wire       spi_clk,
   input  wire       lin_level,
   input  wire       load_current_threshold,
   input  wire       direct_drive_pin,
   input  wire       rx_data,
   // Host commands, one-cycle pulses
   input  wire       cmd_reg_stby,
   input  wire       cmd_bat_stby,
   // Configuration from SPI registers
   input  wire [1:0] high_side_cfg,
   input  wire       relay_cfg,
   input  wire       direct_drive_en,
   input  wire       fail_safe_active,
   // Outputs
   output reg  [1:0] mode,
   output reg        rx_or_wake_irq_pin,
   output reg        host_reset_out_n,
   output reg        main_regulator,
   output reg        regulator_high_current,
   output reg        watchdog_en,
   output reg        watchdog_long_window,
   output reg        relay_on,
   output reg        lin_tx_en,
   output reg  [1:0] high_side_out,
   output reg        fail_safe_output,
   output reg        oscillator_on,
   output reg        spi_enable
);
   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   wire flash_s;
   wire csn_s;
   wire sck_s;
   wire lin_s;
   wire load_s;
   wire lin_wake;
   sync2 u_flash (.mclk(mclk), .rst(rst), .d(flash_level),            .q(flash_s));
   sync2 u_csn   (.mclk(mclk), .rst(rst), .d(chip_select_n),          .q(csn_s));
   sync2 u_sck   (.mclk(mclk), .rst(rst), .d(spi_clk),                .q(sck_s));
   sync2 u_lin   (.mclk(mclk), .rst(rst), .d(lin_level),              .q(lin_s));
   sync2 u_load  (.mclk(mclk), .rst(rst), .d(load_current_threshold), .q(load_s));

   reg              sck_d;
   reg              sck_seen;
   reg              fs_latched;
   reg [1:0]        hs_held;
   reg [`CNT_W-1:0] pulse_cnt;
   reg [`CNT_W-1:0] next_pulse_cnt;
   reg              next_irq_pin;
   reg [1:0]        next_mode;
   reg              arm;
   reg              next_main_regulator;
   reg              next_high_current;
   reg              next_watchdog_en;
   reg              next_long_window;
   reg              next_relay_on;
   reg              next_lin_tx_en;
   reg [1:0]        next_high_side_out;
   reg              next_fail_safe_output;
   reg              next_oscillator_on;
   reg              next_spi_enable;
   localparam [`CNT_W-1:0] PULSE_LAST = {{(`CNT_W-1){1'b0}}, 1'b1};

   // ---------------------------------------------------------------
   // Mode decoding helpers
   // ---------------------------------------------------------------
   // True in either standby mode.
   function is_standby;
      input [1:0] m;
      begin
         is_standby = (m == `MODE_REG_STBY) || (m == `MODE_BAT_STBY);
      end
   endfunction

   // True on the clock that leaves active mode for a standby mode.
   function standby_entry;
      input [1:0] cur;
      input [1:0] nxt;
      begin
         standby_entry = (cur == `MODE_ACTIVE) && is_standby(nxt);
      end
   endfunction

   // High sides in standby: the live setting on the entry clock, the held copy afterwards.
   function [1:0] held_high_side;
      input [1:0] cur;
      input [1:0] cfg;
      input [1:0] held;
      begin
         held_high_side = (cur == `MODE_ACTIVE) ? cfg : held;
      end
   endfunction

   // Fail-safe output in standby, chosen the same way as the high sides.
   function held_fail_safe;
      input [1:0] cur;
      input       live;
      input       held;
      begin
         held_fail_safe = (cur == `MODE_ACTIVE) ? live : held;
      end
   endfunction

   wire standby  = is_standby(mode);
   wire sck_rise = sck_s & ~sck_d;
   // First rising clock edge with chip-select low.
   wire spi_wake = (mode == `MODE_REG_STBY) && !csn_s && sck_rise && !sck_seen;

   lin_wake_filter u_lin_filt (
      .mclk      (mclk),
      .rst       (rst),
      .arm       (arm),
      .lin_level (lin_s),
      .wake      (lin_wake)
   );

   // ---------------------------------------------------------------
   // Mode state machine
   // ---------------------------------------------------------------
   always @* begin
      next_mode = mode;
      arm       = 1'b0;
      case (mode)
         `MODE_ACTIVE: begin
            if (flash_s)
               next_mode = `MODE_FLASH;
            else if (cmd_reg_stby)
               next_mode = `MODE_REG_STBY;
            else if (cmd_bat_stby)
               next_mode = `MODE_BAT_STBY;
            arm = standby_entry(mode, next_mode);
         end
         `MODE_FLASH: begin
            if (!flash_s)
               next_mode = `MODE_ACTIVE;
         end
         `MODE_REG_STBY: begin
            if (lin_wake || spi_wake)
               next_mode = `MODE_ACTIVE;
         end
         `MODE_BAT_STBY: begin
            if (lin_wake)
               next_mode = `MODE_ACTIVE;
         end
         default: next_mode = `MODE_ACTIVE;
      endcase
   end

   // ---------------------------------------------------------------
   // Mode register and SPI clock edge tracking
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         mode             <= `MODE_ACTIVE;
         sck_d            <= 1'b0;
         sck_seen         <= 1'b0;
         host_reset_out_n <= 1'b0;
      end else begin
         mode             <= next_mode;
         sck_d            <= sck_s;
         // Leaving flash mode never pulls the host reset low.
         host_reset_out_n <= 1'b1;
         // Only the first clock rise of an access counts as a wake.
         if (csn_s)
            sck_seen <= 1'b0;
         else if (sck_rise)
            sck_seen <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Settings captured on standby entry
   // ---------------------------------------------------------------
   // The host may rewrite its settings later; standby keeps the values seen at entry.
   always @(posedge mclk) begin
      if (rst) begin
         hs_held    <= 2'h0;
         fs_latched <= 1'b0;
      end else if (standby_entry(mode, next_mode)) begin
         hs_held    <= high_side_cfg;
         fs_latched <= fail_safe_active;
      end
   end

   // ---------------------------------------------------------------
   // Wake pulse on the shared receive pin
   // ---------------------------------------------------------------
   always @* begin
      next_pulse_cnt = pulse_cnt;
      next_irq_pin   = rx_data;
      // A wake from either standby mode starts the pulse.
      if (standby && next_mode == `MODE_ACTIVE) begin
         next_pulse_cnt = `WAKE_PULSE_CYC;
         next_irq_pin   = 1'b0;
      end else if (pulse_cnt != {`CNT_W{1'b0}}) begin
         next_pulse_cnt = pulse_cnt - 1'b1;
         // The pin is handed back to the receiver on the last count.
         next_irq_pin   = (pulse_cnt == PULSE_LAST) ? rx_data : 1'b0;
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         pulse_cnt          <= {`CNT_W{1'b0}};
         rx_or_wake_irq_pin <= 1'b1;
      end else begin
         pulse_cnt          <= next_pulse_cnt;
         rx_or_wake_irq_pin <= next_irq_pin;
      end
   end

   // ---------------------------------------------------------------
   // Supply and watchdog per mode
   // ---------------------------------------------------------------
   always @* begin
      next_main_regulator = 1'b1;
      next_high_current   = 1'b1;
      next_watchdog_en    = 1'b1;
      next_long_window    = watchdog_long_window;
      case (next_mode)
         `MODE_ACTIVE: begin
            // Any return to active mode restarts the watchdog with its long window.
            if (mode != `MODE_ACTIVE)
               next_long_window = 1'b1;
         end
         `MODE_FLASH: begin
            next_watchdog_en = 1'b0;
            next_long_window = 1'b1;
         end
         `MODE_REG_STBY: begin
            // Below the current threshold the regulator drops to low current and the watchdog stops.
            next_main_regulator = 1'b1;
            next_high_current   = load_s;
            next_watchdog_en    = load_s;
            if (load_s && !watchdog_en)
               next_long_window = 1'b1;
         end
         `MODE_BAT_STBY: begin
            next_main_regulator = 1'b0;
            next_high_current   = 1'b0;
            next_watchdog_en    = 1'b0;
            next_long_window    = 1'b1;
         end
         default: begin
            // Unreachable with four two-bit codes.
            next_main_regulator = 1'b1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Drivers and housekeeping per mode
   // ---------------------------------------------------------------
   always @* begin
      next_relay_on         = relay_cfg;
      next_lin_tx_en        = 1'b1;
      next_high_side_out    = high_side_cfg;
      next_fail_safe_output = fail_safe_active;
      next_oscillator_on    = 1'b1;
      next_spi_enable       = 1'b1;
      case (next_mode)
         `MODE_ACTIVE: begin
            next_spi_enable = 1'b1;
         end
         `MODE_FLASH: begin
            // The SPI is shut off while the host is being programmed.
            next_spi_enable = 1'b0;
         end
         `MODE_REG_STBY: begin
            next_relay_on  = 1'b0;
            next_lin_tx_en = 1'b0;
            // Direct drive lets the high sides supply external contacts cyclically.
            if (direct_drive_en)
               next_high_side_out = {2{direct_drive_pin}};
            else
               next_high_side_out = held_high_side(mode, high_side_cfg, hs_held);
            next_fail_safe_output = held_fail_safe(mode, fail_safe_active, fs_latched);
            next_oscillator_on    = direct_drive_en & direct_drive_pin;
         end
         `MODE_BAT_STBY: begin
            next_relay_on         = 1'b0;
            next_lin_tx_en        = 1'b0;
            next_high_side_out    = held_high_side(mode, high_side_cfg, hs_held);
            next_fail_safe_output = held_fail_safe(mode, fail_safe_active, fs_latched);
            next_oscillator_on    = 1'b0;
            next_spi_enable       = 1'b0;
         end
         default: begin
            // Unreachable with four two-bit codes.
            next_spi_enable = 1'b1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Supply and watchdog registers
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         main_regulator         <= 1'b1;
         regulator_high_current <= 1'b1;
         watchdog_en            <= 1'b0;
         watchdog_long_window   <= 1'b1;
      end else begin
         main_regulator         <= next_main_regulator;
         regulator_high_current <= next_high_current;
         watchdog_en            <= next_watchdog_en;
         watchdog_long_window   <= next_long_window;
      end
   end

   // ---------------------------------------------------------------
   // Driver and housekeeping registers
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         relay_on         <= 1'b0;
         lin_tx_en        <= 1'b0;
         high_side_out    <= 2'h0;
         fail_safe_output <= 1'b0;
         oscillator_on    <= 1'b1;
         spi_enable       <= 1'b0;
      end else begin
         relay_on         <= next_relay_on;
         lin_tx_en        <= next_lin_tx_en;
         high_side_out    <= next_high_side_out;
         fail_safe_output <= next_fail_safe_output;
         oscillator_on    <= next_oscillator_on;
         spi_enable       <= next_spi_enable;
      end
   end
endmodule // operating_mode_controller

// File: logic/mode_ctl_defs.vh
`ifndef MODE_CTL_DEFS_VH
`define MODE_CTL_DEFS_VH
`define MODE_ACTIVE      2'h0
`define MODE_FLASH       2'h1
`define MODE_REG_STBY    2'h2
`define MODE_BAT_STBY    2'h3
// Wake pulse of 50 us and LIN filter of 30 us, counted in 100 ns clocks.
`define WAKE_PULSE_CYC   10'h1F4
`define LIN_FILTER_CYC   10'h12C
`define CNT_W            10
`endif

// File: logic/sync2.v
`timescale 1ns/1ps
// Two flip-flop synchroniser for one level.
module sync2 (
   // Clock and reset
   input  wire mclk,
   input  wire rst,
   // Data
   input  wire d,
   output reg  q
);
   reg meta;
   always @(posedge mclk) begin
      if (rst) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // sync2

// File: logic/lin_wake_filter.v
`timescale 1ns/1ps
`include "mode_ctl_defs.vh"
// Stores the bus level on arm and flags a change that persists for the filter time.
module lin_wake_filter (
   // Clock and reset
   input  wire mclk,
   input  wire rst,
   // Control
   input  wire arm,
   input  wire lin_level,
   output reg  wake
);
   reg              stored;
   reg [`CNT_W-1:0] cnt;
   always @(posedge mclk) begin
      if (rst) begin
         stored <= 1'b1;
         cnt    <= {`CNT_W{1'b0}};
         wake   <= 1'b0;
      end else if (arm) begin
         stored <= lin_level;
         cnt    <= {`CNT_W{1'b0}};
         wake   <= 1'b0;
      end else if (lin_level != stored) begin
         if (cnt == `LIN_FILTER_CYC - 1'b1)
            wake <= 1'b1;
         else
            cnt <= cnt + 1'b1;
      end else begin
         cnt  <= {`CNT_W{1'b0}};
         wake <= 1'b0;
      end
   end
endmodule // lin_wake_filter

// File: tb/mode_ctl_props.sv
`timescale 1ns/1ps
// ----
// Checker
// ----
module mode_ctl_props (
   // Clock and reset
   input wire       mclk,
   input wire       rst,
   // Ports
   input wire       flash_level,
   input wire       cmd_reg_stby,
   input wire       cmd_bat_stby,
   input wire       load_current_threshold,
   input wire [1:0] mode,
   input wire       rx_or_wake_irq_pin,
   input wire       host_reset_out_n,
   input wire       main_regulator,
   input wire       regulator_high_current,
   input wire       watchdog_en,
   input wire       watchdog_long_window,
   input wire       relay_on,
   input wire       lin_tx_en,
   input wire       spi_enable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   reg_entry_a: assert property (((!flash_level)[*4] ##0 (mode == 2'h0 && cmd_reg_stby)) |=> mode == 2'h2)
      else $error("no reg standby");
   bat_entry_a: assert property (((!flash_level)[*4] ##0 (mode == 2'h0 && cmd_bat_stby && !cmd_reg_stby))
      |=> mode == 2'h3) else $error("no bat standby");
   no_cmd_stay_a: assert property ((mode == 2'h0 && !cmd_reg_stby && !cmd_bat_stby) |=> !mode[1])
      else $error("standby without command");
   reg_stby_off_a: assert property (mode == 2'h2 |-> !relay_on && !lin_tx_en)
      else $error("relay or lin on");
   bat_stby_off_a: assert property (mode == 2'h3 |-> !main_regulator && !relay_on && !lin_tx_en)
      else $error("bat standby output on");
   flash_off_a: assert property (mode == 2'h1 |-> !watchdog_en && !spi_enable)
      else $error("flash watchdog or spi on");
   flash_exit_a: assert property (($past(mode) == 2'h1 && mode == 2'h0)
      |-> host_reset_out_n[*3] ##0 watchdog_long_window) else $error("flash exit");
   wake_pulse_a: assert property (($past(mode[1]) && mode == 2'h0) |-> ##1 (!rx_or_wake_irq_pin)[*8])
      else $error("no wake pulse");
   cur_high_a: assert property ((mode == 2'h2 && load_current_threshold)[*6]
      |-> regulator_high_current && watchdog_en) else $error("high current");
   cur_low_a: assert property ((mode == 2'h2 && !load_current_threshold)[*6]
      |-> main_regulator && !regulator_high_current && !watchdog_en) else $error("low current");
   cover property (mode == 2'h0 ##1 mode == 2'h2);
   cover property (mode == 2'h3 ##1 mode == 2'h0);
   cover property (mode == 2'h1 ##1 mode == 2'h0);
endmodule // mode_ctl_props

bind operating_mode_controller mode_ctl_props props_u (.mclk, .rst, .flash_level, .cmd_reg_stby, .cmd_bat_stby,
   .load_current_threshold, .mode, .rx_or_wake_irq_pin, .host_reset_out_n, .main_regulator,
   .regulator_high_current, .watchdog_en, .watchdog_long_window, .relay_on, .lin_tx_en, .spi_enable);

// File: tb/host_model.sv
`timescale 1ns/1ps
// ----
// Host side
// ----
module host_model (
   // Clock
   input wire mclk,
   // Host pins and decoded commands
   output reg chip_select_n = 1'b1,
   output reg spi_clk       = 1'b0,
   output reg cmd_reg_stby  = 1'b0,
   output reg cmd_bat_stby  = 1'b0
);
   // One-cycle standby command: sel 0 for regulator-on, 1 for battery-only.
   task send_cmd(input reg sel);
      begin
         @(posedge mclk);
         cmd_reg_stby <= !sel;
         cmd_bat_stby <= sel;
         @(posedge mclk);
         cmd_reg_stby <= 1'b0;
         cmd_bat_stby <= 1'b0;
      end
   endtask
   task spi_access;
      begin
         @(posedge mclk) chip_select_n <= 1'b0;
         repeat (4) @(posedge mclk);
         spi_clk <= 1'b1;
         repeat (4) @(posedge mclk);
         spi_clk <= 1'b0;
         chip_select_n <= 1'b1;
      end
   endtask
endmodule // host_model

// File: tb/tb.sv
`timescale 1ns/1ps
`include "mode_ctl_defs.vh"
// ----
// Testbench
// ----
module tb;
   reg        mclk = 1'b0, rst = 1'b1, flash_level = 1'b0, lin_level = 1'b1, load_current_threshold = 1'b0;
   reg        direct_drive_pin = 1'b0, rx_data = 1'b1, relay_cfg = 1'b1, direct_drive_en = 1'b0;
   reg        fail_safe_active = 1'b0;
   reg  [1:0] high_side_cfg = 2'h0;
   wire       chip_select_n, spi_clk, cmd_reg_stby, cmd_bat_stby, rx_or_wake_irq_pin, host_reset_out_n;
   wire       main_regulator, regulator_high_current, watchdog_en, watchdog_long_window, relay_on, lin_tx_en;
   wire       fail_safe_output, oscillator_on, spi_enable;
   wire [1:0] mode, high_side_out;
   integer    fail_count = 0, samples_checked = 0, n, low_cnt = 0;
   always #50 mclk = ~mclk;
   always @(posedge mclk) if (rx_or_wake_irq_pin === 1'b0) low_cnt <= low_cnt + 1;
   host_model host_u (.mclk, .chip_select_n, .spi_clk, .cmd_reg_stby, .cmd_bat_stby);
   operating_mode_controller dut_u (.mclk, .rst, .flash_level, .chip_select_n, .spi_clk, .lin_level,
      .load_current_threshold, .direct_drive_pin, .rx_data, .cmd_reg_stby, .cmd_bat_stby, .high_side_cfg,
      .relay_cfg, .direct_drive_en, .fail_safe_active, .mode, .rx_or_wake_irq_pin, .host_reset_out_n,
      .main_regulator, .regulator_high_current, .watchdog_en, .watchdog_long_window, .relay_on, .lin_tx_en,
      .high_side_out, .fail_safe_output, .oscillator_on, .spi_enable);
   task check(input [8*8:1] what, input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task cyc(input integer k);
      repeat (k) @(posedge mclk);
   endtask
   task wait_mode(input [1:0] m, input integer lim);
      begin
         for (n = 0; mode !== m && n < lim; n = n + 1) @(posedge mclk);
         check("mode", mode, m);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      cyc(5000);
      fail_count = fail_count + 1;
      report_and_stop;
   end
   initial begin
      cyc(16);
      rst <= 1'b0;
      cyc(4);
      check("mode", mode, `MODE_ACTIVE);
      check("rst_n", host_reset_out_n, 1'b1);
      check("spi_en", spi_enable, 1'b1);
      check("lin_tx", lin_tx_en, 1'b1);
      $display("test reset done");
      high_side_cfg <= 2'h2;
      host_u.send_cmd(1'b0);
      cyc(8);
      check("mode", mode, `MODE_REG_STBY);
      check("relay", relay_on, 1'b0);
      check("lin_tx", lin_tx_en, 1'b0);
      check("reg_on", main_regulator, 1'b1);
      check("hicur", regulator_high_current, 1'b0);
      check("wd_en", watchdog_en, 1'b0);
      check("hs", high_side_out, 2'h2);
      check("fso", fail_safe_output, 1'b0);
      load_current_threshold <= 1'b1;
      cyc(8);
      check("mode", mode, `MODE_REG_STBY);
      check("irq", rx_or_wake_irq_pin, 1'b1);
      check("hicur", regulator_high_current, 1'b1);
      check("wd_en", watchdog_en, 1'b1);
      check("long_win", watchdog_long_window, 1'b1);
      load_current_threshold <= 1'b0;
      direct_drive_en <= 1'b1;
      direct_drive_pin <= 1'b1;
      cyc(6);
      check("hs", high_side_out, 2'h3);
      check("osc", oscillator_on, 1'b1);
      direct_drive_pin <= 1'b0;
      cyc(6);
      check("osc", oscillator_on, 1'b0);
      direct_drive_en <= 1'b0;
      low_cnt = 0;
      host_u.spi_access;
      wait_mode(`MODE_ACTIVE, 20);
      cyc(600);
      check("pulse", low_cnt, `WAKE_PULSE_CYC);
      $display("test reg standby done");
      fail_safe_active <= 1'b1;
      host_u.send_cmd(1'b1);
      cyc(4);
      fail_safe_active <= 1'b0;
      check("mode", mode, `MODE_BAT_STBY);
      check("reg_on", main_regulator, 1'b0);
      check("relay", relay_on, 1'b0);
      check("spi_en", spi_enable, 1'b0);
      check("hs", high_side_out, 2'h2);
      cyc(4);
      check("fso", fail_safe_output, 1'b1);
      host_u.spi_access;
      cyc(6);
      check("mode", mode, `MODE_BAT_STBY);
      lin_level <= 1'b0;
      cyc(100);
      lin_level <= 1'b1;
      cyc(300);
      check("mode", mode, `MODE_BAT_STBY);
      lin_level <= 1'b0;
      cyc(`LIN_FILTER_CYC - 10);
      check("mode", mode, `MODE_BAT_STBY);
      wait_mode(`MODE_ACTIVE, 30);
      cyc(2);
      check("irq", rx_or_wake_irq_pin, 1'b0);
      check("fso", fail_safe_output, 1'b0);
      $display("test bat standby done");
      flash_level <= 1'b1;
      cyc(5);
      check("mode", mode, `MODE_FLASH);
      check("wd_en", watchdog_en, 1'b0);
      check("spi_en", spi_enable, 1'b0);
      host_u.send_cmd(1'b0);
      cyc(2);
      check("mode", mode, `MODE_FLASH);
      flash_level <= 1'b0;
      cyc(5);
      check("mode", mode, `MODE_ACTIVE);
      check("rst_n", host_reset_out_n, 1'b1);
      check("long_win", watchdog_long_window, 1'b1);
      check("wd_en", watchdog_en, 1'b1);
      $display("test flash done");
      report_and_stop;
   end
endmodule // tb
